// ==== maintenance_command_executor_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module maintenance_command_executor_tb;
    logic clk_sys_i, rst_b_i, ce_i, wr_en_i, cfg_done_i;
    logic [15:0] wr_addr_i, wr_data_i;
    logic [3:0] blk;
    logic alarm_reset_o, abs_alarm_reset_o, alarm_hist_clear_o, warn_hist_clear_o, link_err_hist_clear_o;
    logic pos_preset_o, cfg_start_o, cfg_busy_o, brake_hold_o, excite_off_o, alarm_led_off_o, inputs_ignore_o;
    logic outputs_undef_o, auto_return_block_o, factory_default_o, nvm_load_o, nvm_overwrite_all_o, nvm_store_o;
    logic [7:0] default_mask_o;
    logic [15:0] row_addr [10];
    logic [9:0] row_exp [10];
    int num_errors, cmp_count, cyc;
    wire logic alarm_active_i = blk[0];
    wire logic motor_moving_i = blk[1];
    wire logic tool_busy_i = blk[2];
    wire logic handheld_test_copy_i = blk[3];
    wire logic [9:0] pv = {nvm_store_o, nvm_load_o, factory_default_o, cfg_start_o, pos_preset_o,
        link_err_hist_clear_o, warn_hist_clear_o, alarm_hist_clear_o, abs_alarm_reset_o, alarm_reset_o};
    wire logic [5:0] cv = {cfg_busy_o, brake_hold_o, excite_off_o, alarm_led_off_o, inputs_ignore_o, outputs_undef_o};
    mce_maint_cmd mce_maint_cmd_i (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i),
        .wr_data_i(wr_data_i),
        .alarm_active_i(alarm_active_i),
        .motor_moving_i(motor_moving_i),
        .tool_busy_i(tool_busy_i),
        .handheld_test_copy_i(handheld_test_copy_i),
        .cfg_done_i(cfg_done_i),
        .alarm_reset_o(alarm_reset_o),
        .abs_alarm_reset_o(abs_alarm_reset_o),
        .alarm_hist_clear_o(alarm_hist_clear_o),
        .warn_hist_clear_o(warn_hist_clear_o),
        .link_err_hist_clear_o(link_err_hist_clear_o),
        .pos_preset_o(pos_preset_o),
        .cfg_start_o(cfg_start_o),
        .cfg_busy_o(cfg_busy_o),
        .brake_hold_o(brake_hold_o),
        .excite_off_o(excite_off_o),
        .alarm_led_off_o(alarm_led_off_o),
        .inputs_ignore_o(inputs_ignore_o),
        .outputs_undef_o(outputs_undef_o),
        .auto_return_block_o(auto_return_block_o),
        .factory_default_o(factory_default_o),
        .default_mask_o(default_mask_o),
        .nvm_load_o(nvm_load_o),
        .nvm_overwrite_all_o(nvm_overwrite_all_o),
        .nvm_store_o(nvm_store_o)
    );
    mce_master_model mst_i (.clk_sys_i, .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i));
    // Clock and hang guard
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // Main sequence: reset, command table, then the awkward cases
    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        cfg_done_i = 1'b0;
        blk = 4'h0;
        for (int i = 0; i < 10; i++) begin
            row_addr[i] = 16'h0180 + 16'(2 * i);
            row_exp[i] = 10'h001 << i;
        end
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        @(negedge clk_sys_i);
        chk({pv, cv}, 16'h0000); // Quiet after reset
        for (int i = 0; i < 10; i++) begin
            mst_i.put(row_addr[i], 32'h1);
            @(negedge clk_sys_i);
            chk(16'(pv), 16'(row_exp[i])); // One pulse
            chk(16'(default_mask_o), i == 7 ? 16'h00f8 : 16'h0000); // Kept link bits
            chk(16'(nvm_overwrite_all_o), 16'(i == 8)); // Overwrite all
            if (i == 6) begin
                chk(16'(cv), 16'h003f); // Forced levels
                cfg_done_i = 1'b1;
                @(negedge clk_sys_i);
                cfg_done_i = 1'b0;
                repeat (3) @(negedge clk_sys_i);
                chk(16'({cv, auto_return_block_o}), 16'h0001); // No return
            end
        end
        mst_i.put(16'h0180, 32'h1);
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0000); // Unchanged value
        mst_i.put(16'h0180, 32'h0); // Rearm
        mst_i.put(16'h0180, 32'h0001_0000);
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0000); // Upper bit only
        for (int k = 0; k < 4; k++) begin
            mst_i.put(16'h018c, 32'h0); // Rearm
            blk = 4'h1 << k;
            mst_i.put(16'h018c, 32'h1);
            @(negedge clk_sys_i);
            chk({pv, cv}, 16'h0000); // Blocked
            blk = 4'h0;
            repeat (3) @(negedge clk_sys_i);
            chk({pv, cv}, 16'h0000); // Not queued
        end
        chk(16'(auto_return_block_o), 16'h0000); // Released by motion
        // Clock enable low holds a pending launch, then holds the pulse
        mst_i.put(16'h0186, 32'h0); // Rearm
        mst_i.put(16'h0186, 32'h1);
        ce_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(16'(pv), 16'h0000); // Held while frozen
        ce_i = 1'b1;
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0008); // Launch after thaw
        ce_i = 1'b0;
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0008); // Pulse stands while frozen
        ce_i = 1'b1;
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0000); // Pulse ends
        // Second trigger while configuring is dropped, then reset mid-run
        mst_i.put(16'h018c, 32'h0); // Rearm
        mst_i.put(16'h018c, 32'h1);
        @(negedge clk_sys_i);
        chk(16'(cv), 16'h003f); // Configuring
        mst_i.put(16'h018c, 32'h0); // Rearm
        mst_i.put(16'h018c, 32'h1);
        @(negedge clk_sys_i);
        chk({pv, cv}, 16'h003f); // No restart while busy
        rst_b_i = 1'b0;
        @(negedge clk_sys_i);
        chk({pv, cv}, 16'h0000); // Reset clears levels
        chk(16'({default_mask_o, nvm_overwrite_all_o, auto_return_block_o}), 16'h0000); // Reset clears
        rst_b_i = 1'b1;
        mst_i.put(16'h0182, 32'h1);
        @(negedge clk_sys_i);
        chk(16'(pv), 16'h0002); // Values cleared by reset
        final_report();
    end
endmodule : maintenance_command_executor_tb
`default_nettype wire

// ==== mce_maint_cmd.sv ====
// Summary of operation
// R1: Launch only on written zero-to-one transition
// R2: Alarm reset clears resettable active alarms
// R3: Dedicated command clears absolute position alarm
// R4: Alarm history clear erases past alarms
// R5: Warning history clear erases past warnings
// R6: Link error history clear erases records
// R7: Position preset loads command position counter
// R8: Configuration recomputes derived values, applies setup
// R9: Full initialization restores factory defaults
// R10: Initialization keeps parity, stop bits, delay
// R11: Batch read copies non-volatile parameters to RAM
// R12: Batch read overwrites all RAM data
// R13: Batch write copies RAM parameters to non-volatile
// R14: Configure only without alarm and motion
// R15: No configure during tool download or tests
// R16: No configure in handheld test/copy mode
// R17: During configure: brake, no excitation, inputs ignored
// R18: Master ignores monitor values during configure
// R19: No automatic return right after configure
// R20: Blocked configure trigger discarded, never queued
// R21: Master writes zero before writing one again
`include "mce_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module mce_maint_cmd (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic alarm_active_i,
    input wire logic motor_moving_i,
    input wire logic tool_busy_i,
    input wire logic handheld_test_copy_i,
    input wire logic cfg_done_i,
    output logic alarm_reset_o,
    output logic abs_alarm_reset_o,
    output logic alarm_hist_clear_o,
    output logic warn_hist_clear_o,
    output logic link_err_hist_clear_o,
    output logic pos_preset_o,
    output logic cfg_start_o,
    output logic cfg_busy_o,
    output logic brake_hold_o,
    output logic excite_off_o,
    output logic alarm_led_off_o,
    output logic inputs_ignore_o,
    output logic outputs_undef_o,
    output logic auto_return_block_o,
    output logic factory_default_o,
    output logic [`MCE_DEF_MASK_WIDTH-1:0] default_mask_o,
    output logic nvm_load_o,
    output logic nvm_overwrite_all_o,
    output logic nvm_store_o
);

    logic [31:0] cmd_val_r [0:`MCE_CMD_COUNT-1];
    logic [`MCE_CMD_COUNT-1:0] fire_r;
    logic cfg_ok;
    logic cfg_launch;
    logic cfg_finish;
    mce_pkg::mce_cfg_state_t cfg_state_r;

    // Per-command word storage and rising-transition detection
    genvar gi;
    generate
        for (gi = 0; gi < `MCE_CMD_COUNT; gi = gi + 1) begin : g_cmd
            localparam logic [15:0] UPPER_ADDR = 16'(`MCE_ADDR_BASE + gi * `MCE_WORD_STRIDE);
            localparam logic [15:0] LOWER_ADDR = 16'(`MCE_ADDR_BASE + gi * `MCE_WORD_STRIDE + 1);
            logic wr_upper;
            logic wr_lower;
            logic [31:0] val_nxt;
            assign wr_upper = wr_en_i && (wr_addr_i == UPPER_ADDR);
            assign wr_lower = wr_en_i && (wr_addr_i == LOWER_ADDR);
            assign val_nxt = {cmd_val_r[gi][31:16], wr_data_i};

            // Stored value of the command pair
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    cmd_val_r[gi] <= `MCE_CMD_RESET;
                end else if (ce_i) begin
                    if (wr_upper) begin
                        cmd_val_r[gi] <= {wr_data_i, cmd_val_r[gi][15:0]};
                    end else if (wr_lower) begin
                        cmd_val_r[gi] <= val_nxt;
                    end
                end
            end

            // Launch when a lower write takes the pair from 0 to 1
            always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    fire_r[gi] <= 1'b0;
                end else if (ce_i) begin
                    fire_r[gi] <= wr_lower && (cmd_val_r[gi] == `MCE_CMD_IDLE_VALUE)
                        && (val_nxt == `MCE_CMD_FIRE_VALUE); // [R1] [R21]
                end
            end
        end
    endgenerate

    // Alarm reset pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_reset_o <= 1'b0;
        end else if (ce_i) begin
            alarm_reset_o <= fire_r[`MCE_IDX_ALARM_RESET]; // [R2]
        end
    end

    // Absolute position alarm reset pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            abs_alarm_reset_o <= 1'b0;
        end else if (ce_i) begin
            abs_alarm_reset_o <= fire_r[`MCE_IDX_ABS_ALARM_RESET]; // [R3]
        end
    end

    // Alarm history clear pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_hist_clear_o <= 1'b0;
        end else if (ce_i) begin
            alarm_hist_clear_o <= fire_r[`MCE_IDX_ALARM_HIST_CLR]; // [R4]
        end
    end

    // Warning history clear pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            warn_hist_clear_o <= 1'b0;
        end else if (ce_i) begin
            warn_hist_clear_o <= fire_r[`MCE_IDX_WARN_HIST_CLR]; // [R5]
        end
    end

    // Link error history clear pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_err_hist_clear_o <= 1'b0;
        end else if (ce_i) begin
            link_err_hist_clear_o <= fire_r[`MCE_IDX_LINK_ERR_CLR]; // [R6]
        end
    end

    // Command position preset pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pos_preset_o <= 1'b0;
        end else if (ce_i) begin
            pos_preset_o <= fire_r[`MCE_IDX_POS_PRESET]; // [R7]
        end
    end

    // Default restore pulse with the mask of link settings it must keep
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            factory_default_o <= 1'b0;
            default_mask_o <= '0;
        end else if (ce_i) begin
            factory_default_o <= fire_r[`MCE_IDX_FACTORY_DEFAULT]; // [R9]
            default_mask_o <= fire_r[`MCE_IDX_FACTORY_DEFAULT] ? `MCE_DEF_MASK_KEEP_LINK : '0; // [R10]
        end
    end

    // Load from non-volatile memory, overwriting all working data
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nvm_load_o <= 1'b0;
            nvm_overwrite_all_o <= 1'b0;
        end else if (ce_i) begin
            nvm_load_o <= fire_r[`MCE_IDX_NVM_LOAD]; // [R11]
            nvm_overwrite_all_o <= fire_r[`MCE_IDX_NVM_LOAD]; // [R12]
        end
    end

    // Store of working parameters into non-volatile memory
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nvm_store_o <= 1'b0;
        end else if (ce_i) begin
            nvm_store_o <= fire_r[`MCE_IDX_NVM_STORE]; // [R13]
        end
    end

    // Preconditions for configuration
    assign cfg_ok = !alarm_active_i && !motor_moving_i // [R14]
        && !tool_busy_i // [R15]
        && !handheld_test_copy_i; // [R16]

    // Accepted trigger and completion of a configuration run
    assign cfg_launch = (cfg_state_r == mce_pkg::MCE_CFG_IDLE) && fire_r[`MCE_IDX_RECONFIGURE] && cfg_ok; // [R20]
    assign cfg_finish = (cfg_state_r == mce_pkg::MCE_CFG_RUN) && cfg_done_i;

    // Configuration sequencer; a trigger outside idle is dropped
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_state_r <= mce_pkg::MCE_CFG_IDLE;
        end else if (ce_i) begin
            case (cfg_state_r)
                mce_pkg::MCE_CFG_IDLE: begin
                    if (cfg_launch) begin // [R20]
                        cfg_state_r <= mce_pkg::MCE_CFG_RUN; // [R8]
                    end
                end
                mce_pkg::MCE_CFG_RUN: begin
                    if (cfg_done_i) begin
                        cfg_state_r <= mce_pkg::MCE_CFG_DONE;
                    end
                end
                mce_pkg::MCE_CFG_DONE: begin
                    cfg_state_r <= mce_pkg::MCE_CFG_IDLE;
                end
                default: begin
                    cfg_state_r <= mce_pkg::MCE_CFG_IDLE;
                end
            endcase
        end
    end

    // Start pulse for the recompute engine
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_start_o <= 1'b0;
        end else if (ce_i) begin
            cfg_start_o <= cfg_launch; // [R8]
        end
    end

    // Busy level from start until completion is seen
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_busy_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_launch) begin
                cfg_busy_o <= 1'b1; // [R17]
            end else if (cfg_finish) begin
                cfg_busy_o <= 1'b0;
            end
        end
    end

    // Brake held and excitation removed while configuring
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            brake_hold_o <= 1'b0;
            excite_off_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_launch) begin
                brake_hold_o <= 1'b1; // [R17]
                excite_off_o <= 1'b1; // [R17]
            end else if (cfg_finish) begin
                brake_hold_o <= 1'b0;
                excite_off_o <= 1'b0;
            end
        end
    end

    // Alarm indicator kept dark while configuring
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_led_off_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_launch) begin
                alarm_led_off_o <= 1'b1; // [R17]
            end else if (cfg_finish) begin
                alarm_led_off_o <= 1'b0;
            end
        end
    end

    // Inputs and sensors ignored until completion
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            inputs_ignore_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_launch) begin
                inputs_ignore_o <= 1'b1; // [R17]
            end else if (cfg_finish) begin
                inputs_ignore_o <= 1'b0;
            end
        end
    end

    // Output signals flagged as undefined while configuring
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            outputs_undef_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_launch) begin
                outputs_undef_o <= 1'b1; // [R17]
            end else if (cfg_finish) begin
                outputs_undef_o <= 1'b0;
            end
        end
    end

    // Automatic return held off after configuration until the motor next moves
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            auto_return_block_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_finish) begin
                auto_return_block_o <= 1'b1; // [R19]
            end else if (motor_moving_i) begin
                auto_return_block_o <= 1'b0;
            end
        end
    end

endmodule : mce_maint_cmd

`default_nettype wire

// ==== mce_maint_cmd_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module mce_maint_cmd_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [15:0] wr_addr_i,
    input wire logic alarm_active_i,
    input wire logic motor_moving_i,
    input wire logic tool_busy_i,
    input wire logic handheld_test_copy_i,
    input wire logic cfg_done_i,
    input wire logic alarm_reset_o,
    input wire logic cfg_start_o,
    input wire logic cfg_busy_o,
    input wire logic brake_hold_o,
    input wire logic excite_off_o,
    input wire logic inputs_ignore_o,
    input wire logic auto_return_block_o,
    input wire logic factory_default_o,
    input wire logic [7:0] default_mask_o,
    input wire logic nvm_load_o,
    input wire logic nvm_overwrite_all_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Completion step of a configuration run
    sequence cfg_end_s;
        !cfg_busy_o && auto_return_block_o;
    endsequence
    pulse_width_a: assert property (alarm_reset_o && ce_i |=> !alarm_reset_o) else $error("long pulse");
    alarm_cause_a: assert property ($rose(alarm_reset_o) && $past(ce_i, 2) |->
        $past(wr_en_i && wr_addr_i == 16'h0181, 2))
        else $error("alarm reset without write");
    mask_keep_a: assert property (factory_default_o |-> default_mask_o == 8'hf8) else $error("mask");
    load_all_a: assert property (nvm_overwrite_all_o == nvm_load_o) else $error("load pair");
    cfg_idle_a: assert property (cfg_start_o |-> $past(!alarm_active_i && !motor_moving_i))
        else $error("config while busy motor");
    cfg_tool_a: assert property (cfg_start_o |-> $past(!tool_busy_i && !handheld_test_copy_i))
        else $error("config while tool active");
    cfg_forced_a: assert property ({brake_hold_o, excite_off_o, inputs_ignore_o} == {3{cfg_busy_o}})
        else $error("forced levels");
    cfg_end_a: assert property (cfg_busy_o && cfg_done_i && ce_i |-> ##[1:2] cfg_end_s) else $error("end");
endmodule : mce_maint_cmd_monitor
bind mce_maint_cmd mce_maint_cmd_monitor mon_i (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i),
    .alarm_active_i(alarm_active_i),
    .motor_moving_i(motor_moving_i),
    .tool_busy_i(tool_busy_i),
    .handheld_test_copy_i(handheld_test_copy_i),
    .cfg_done_i(cfg_done_i),
    .alarm_reset_o(alarm_reset_o),
    .cfg_start_o(cfg_start_o),
    .cfg_busy_o(cfg_busy_o),
    .brake_hold_o(brake_hold_o),
    .excite_off_o(excite_off_o),
    .inputs_ignore_o(inputs_ignore_o),
    .auto_return_block_o(auto_return_block_o),
    .factory_default_o(factory_default_o),
    .default_mask_o(default_mask_o),
    .nvm_load_o(nvm_load_o),
    .nvm_overwrite_all_o(nvm_overwrite_all_o)
);
`default_nettype wire

// ==== mce_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mce_master_model (
    input wire logic clk_sys_i,
    output logic wr_en_o = 1'b0,
    output logic [15:0] wr_addr_o = 16'h0000,
    output logic [15:0] wr_data_o = 16'h0000
);
    // Upper then lower word, released lines scrambled; never reads monitors
    task automatic put(input logic [15:0] a, input logic [31:0] v);
        @(negedge clk_sys_i);
        wr_en_o = 1'b1;
        wr_addr_o = a;
        wr_data_o = v[31:16];
        @(negedge clk_sys_i);
        wr_addr_o = a + 16'h0001;
        wr_data_o = v[15:0];
        @(negedge clk_sys_i);
        wr_en_o = 1'b0;
        wr_addr_o = ~wr_addr_o;
        wr_data_o = ~wr_data_o;
    endtask : put
endmodule : mce_master_model
`default_nettype wire

// ==== mce_pkg.sv ====
package mce_pkg;

    // Configuration sequencer states
    typedef enum logic [1:0] {
        MCE_CFG_IDLE = 2'b00,
        MCE_CFG_RUN = 2'b01,
        MCE_CFG_DONE = 2'b10
    } mce_cfg_state_t;

endpackage : mce_pkg

// ==== mce_regs.svh ====
`ifndef MCE_REGS_SVH
`define MCE_REGS_SVH

// Register addresses, each command occupies an upper and a lower word
`define MCE_ADDR_ALARM_RESET      16'h0180
`define MCE_ADDR_ABS_ALARM_RESET  16'h0182
`define MCE_ADDR_ALARM_HIST_CLR   16'h0184
`define MCE_ADDR_WARN_HIST_CLR    16'h0186
`define MCE_ADDR_LINK_ERR_CLR     16'h0188
`define MCE_ADDR_POS_PRESET       16'h018a
`define MCE_ADDR_RECONFIGURE      16'h018c
`define MCE_ADDR_FACTORY_DEFAULT  16'h018e
`define MCE_ADDR_NVM_LOAD         16'h0190
`define MCE_ADDR_NVM_STORE        16'h0192

// First command address and count of commands
`define MCE_ADDR_BASE             16'h0180
`define MCE_CMD_COUNT             10
`define MCE_WORD_STRIDE           2

// Command indexes in address order
`define MCE_IDX_ALARM_RESET       0
`define MCE_IDX_ABS_ALARM_RESET   1
`define MCE_IDX_ALARM_HIST_CLR    2
`define MCE_IDX_WARN_HIST_CLR     3
`define MCE_IDX_LINK_ERR_CLR      4
`define MCE_IDX_POS_PRESET        5
`define MCE_IDX_RECONFIGURE       6
`define MCE_IDX_FACTORY_DEFAULT   7
`define MCE_IDX_NVM_LOAD          8
`define MCE_IDX_NVM_STORE         9

// Reset value of every command register and the launching values
`define MCE_CMD_RESET             32'h0000_0000
`define MCE_CMD_IDLE_VALUE        32'h0000_0000
`define MCE_CMD_FIRE_VALUE        32'h0000_0001

// Restore mask for the default load: bit positions of the kept link settings
`define MCE_DEF_MASK_WIDTH        8
`define MCE_DEF_BIT_LINK_PARITY   0
`define MCE_DEF_BIT_LINK_STOP     1
`define MCE_DEF_BIT_LINK_DELAY    2
`define MCE_DEF_MASK_ALL          8'hff
`define MCE_DEF_MASK_KEEP_LINK    8'hf8

`endif
